// ---- velocity_monitor_regs.svh ----
`ifndef VELOCITY_MONITOR_REGS_SVH
`define VELOCITY_MONITOR_REGS_SVH

// Object indices
`define IDX_MON2        16'h2022
`define IDX_MON3        16'h2023
`define IDX_MON4        16'h2024
`define IDX_DYN         16'h2025
`define IDX_STATUS      16'h2026
`define IDX_IO1         16'h2050

// Sub-indices of a monitor object
`define SUB_COUNT       8'h00
`define SUB_CFG         8'h01
`define SUB_THR         8'h02
`define SUB_HYST        8'h03
`define SUB_START       8'h04
`define SUB_END         8'h05
`define SUB_LAST        8'h05

// Monitor configuration bits
`define CFG_BELOW_BIT   0
`define CFG_DIR_BIT     1
`define CFG_EN_BIT      2
`define CFG_MASK        8'h07

// Switching line configuration bits
`define IO_DIR_BIT      0
`define IO_POL_BIT      1
`define IO_VEL_MAP_BIT  10
`define IO_CFG_MASK     32'hffff_ff03

// Status word bit positions
`define ST_ERR_BIT      0
`define ST_MOVE_BIT     1
`define ST_NEG_BIT      2
`define ST_VIOL_LO      3
`define ST_ACT_LO       8
`define ST_WIDTH        13

// Reset values
`define THR_RST         16'h0000
`define HYST_RST        16'h0064
`define CFG_RST         3'h0
`define IO_CFG_RST      32'h0000_0000

// Accepted ranges
`define SPEED_MAX       16'h4e20
`define POS_MAX         32'h000f_423f
`define POS_MIN         32'hfff0_bdc1

`endif

// ---- velocity_monitor_pkg.sv ----
package velocity_monitor_pkg;

    typedef struct packed {
        logic enable;
        logic dir_dep;
        logic trig_below;
    } vel_cfg_t;

    typedef struct packed {
        logic active;
        logic violation;
    } mon_state_t;

    typedef struct packed {
        vel_cfg_t [3:0]         cfg;
        logic     [3:0][15:0]   thr;
        logic     [3:0][15:0]   hyst;
        logic     [3:0][31:0]   wstart;
        logic     [3:0][31:0]   wend;
        logic     [31:0]        io_cfg;
        logic     [2:0]         io_sync;
        logic                   io_level;
        logic                   io_trigger;
        logic                   io_out;
        logic                   io_oe_n;
        logic                   vel_event;
        logic     [12:0]        status;
        logic                   od_ack;
        logic                   od_err;
        logic     [31:0]        od_rdata;
    } top_state_t;

endpackage : velocity_monitor_pkg

// ---- monitor_check.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "velocity_monitor_regs.svh"

module monitor_check
    import velocity_monitor_pkg::*;
(
    // Clock and reset
    input  wire logic               mclk,
    input  wire logic               reset_n,
    // Settings
    input  wire vel_cfg_t           cfg,
    input  wire logic [15:0]        threshold,
    input  wire logic [15:0]        hysteresis,
    input  wire logic signed [31:0] win_start,
    input  wire logic signed [31:0] win_end,
    // Measurement
    input  wire logic signed [31:0] position,
    input  wire logic signed [31:0] velocity,
    // Result
    output logic                    violation,
    output logic                    active
);

    mon_state_t        state;
    mon_state_t        next_state;
    logic [31:0]       speed;
    logic [32:0]       sp;
    logic [32:0]       t;
    logic [32:0]       h;
    logic signed [31:0] lo;
    logic signed [31:0] hi;
    logic              dir_ok;
    logic              set_cond;
    logic              clr_cond;

    always_comb begin
        speed = velocity[31] ? (~velocity + 32'h0000_0001) : velocity;
        sp = {1'b0, speed};
        t  = {17'h0_0000, threshold};
        h  = {17'h0_0000, hysteresis};
        lo = (win_start < win_end) ? win_start : win_end;
        hi = (win_start < win_end) ? win_end : win_start;
        // With dir_dep set, only travel from start toward end counts
        if (!cfg.dir_dep) begin
            dir_ok = 1'b1;
        end else if (win_start < win_end) begin
            dir_ok = !velocity[31] && (velocity != 32'sh0000_0000);
        end else begin
            dir_ok = velocity[31];
        end
        // Empty window never compares
        next_state.active = cfg.enable && (win_start != win_end)
                            && (position >= lo) && (position <= hi) && dir_ok;
        if (cfg.trig_below) begin
            set_cond = sp < t;
            clr_cond = sp >= t + h;
        end else begin
            set_cond = sp > t;
            clr_cond = sp + h <= t;
        end
        if (!next_state.active) begin
            next_state.violation = 1'b0;
        end else if (state.violation) begin
            next_state.violation = !clr_cond;
        end else begin
            next_state.violation = set_cond;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign violation = state.violation;
    assign active    = state.active;

    a_idle_no_viol: assert property (@(posedge mclk) disable iff (!reset_n)
        !active |-> !violation)
        else $error("violation without active comparison");

    a_empty_window: assert property (@(posedge mclk) disable iff (!reset_n)
        (win_start == win_end) |=> !active && !violation)
        else $error("empty window still compares");

    a_hyst_hold: assert property (@(posedge mclk) disable iff (!reset_n)
        (violation && next_state.active && !cfg.trig_below && (sp + h > t)) |=> violation)
        else $error("violation cleared inside hysteresis band");

    a_dir_reverse: assert property (@(posedge mclk) disable iff (!reset_n)
        (cfg.dir_dep && (win_start < win_end) && velocity[31]) |=> !active)
        else $error("reverse travel compared");

endmodule : monitor_check

`default_nettype wire

// ---- velocity_limit_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "velocity_monitor_regs.svh"

// Summary of operation
// - Config bit 0: trip above or below
// - Config bit 1: any direction or one direction
// - Config bit 2 enables; disabled never violates
// - Threshold 16 bits, 0 to 20000, reset 0
// - Hysteresis 16 bits, 0 to 20000, reset 100
// - Dynamic config bits 3-7 reserved
// - Status bit 0 shows measurement error
// - Status bit 1 shows motion
// - Status bit 2 shows negative direction
// - Status bits 3-7 show violations
// - Status bits 8-12 show active comparisons
// - Line config bit 0: input or output
// - Input: bit 1 picks trigger edge
// - Output: bit 1 picks active level
// - Line config bits 2-7 reserved
// - Equal window ends keep monitor inactive
// - One-way check runs start toward end
// - Violation sets status and mapped output
// - Line event ORs all five violations
module velocity_limit_monitor
    import velocity_monitor_pkg::*;
(
    // Clock and reset
    input  wire logic               mclk,
    input  wire logic               reset_n,
    // Measurement
    input  wire logic signed [31:0] position,
    input  wire logic signed [31:0] velocity,
    input  wire logic               vel_error,
    // First monitor, kept elsewhere
    input  wire logic               monitor1_violation,
    input  wire logic               monitor1_active,
    // Object dictionary access
    input  wire logic [15:0]        od_index,
    input  wire logic [7:0]         od_sub,
    input  wire logic               od_wr,
    input  wire logic               od_rd,
    input  wire logic [31:0]        od_wdata,
    output logic [31:0]             od_rdata,
    output logic                    od_ack,
    output logic                    od_err,
    // Switching line on the power connector
    input  wire logic               io1_in,
    output logic                    io1_out,
    output logic                    io1_oe_n,
    output logic                    io1_trigger,
    // Status
    output logic [12:0]             speed_status,
    output logic                    velocity_event
);

    localparam top_state_t STATE_RESET = '{
        cfg:        {4{`CFG_RST}},
        thr:        {4{`THR_RST}},
        hyst:       {4{`HYST_RST}},
        io_cfg:     `IO_CFG_RST,
        io_oe_n:    1'b1,
        default:    '0
    };

    top_state_t         state;
    top_state_t         next_state;
    logic [3:0]         mon_viol;
    logic [3:0]         mon_act;
    logic [4:0]         all_viol;
    logic [4:0]         all_act;
    logic               is_mon;
    logic [1:0]         m;
    logic               access;
    logic               bad_speed;
    logic               bad_pos;
    logic               any_viol;
    logic               new_level;

    // Monitors two, three, four and dynamic
    for (genvar g = 0; g < 4; g++) begin : g_mon
        monitor_check u_monitor_check (
            .mclk       (mclk),
            .reset_n    (reset_n),
            .cfg        (state.cfg[g]),
            .threshold  (state.thr[g]),
            .hysteresis (state.hyst[g]),
            .win_start  (state.wstart[g]),
            .win_end    (state.wend[g]),
            .position   (position),
            .velocity   (velocity),
            .violation  (mon_viol[g]),
            .active     (mon_act[g])
        );
    end

    always_comb begin
        all_viol  = {mon_viol, monitor1_violation};
        all_act   = {mon_act, monitor1_active};
        any_viol  = |all_viol;
        is_mon    = (od_index >= `IDX_MON2) && (od_index <= `IDX_DYN);
        m         = 2'(od_index - `IDX_MON2);
        access    = od_wr || od_rd;
        bad_speed = (od_wdata[31:16] != 16'h0000) || (od_wdata[15:0] > `SPEED_MAX);
        bad_pos   = ($signed(od_wdata) > $signed(`POS_MAX))
                    || ($signed(od_wdata) < $signed(`POS_MIN));

        next_state = state;

        // Status word
        next_state.status[`ST_ERR_BIT]  = vel_error;
        next_state.status[`ST_MOVE_BIT] = velocity != 32'sh0000_0000;
        next_state.status[`ST_NEG_BIT]  = velocity[31];
        next_state.status[`ST_VIOL_LO +: 5] = all_viol;
        next_state.status[`ST_ACT_LO +: 5]  = all_act;

        // Switching line input path
        next_state.io_sync = {state.io_sync[1:0], io1_in};
        new_level = (state.io_sync[1] == state.io_sync[2]) ? state.io_sync[2] : state.io_level;
        next_state.io_level = new_level;
        if (state.io_cfg[`IO_DIR_BIT]) begin
            next_state.io_trigger = 1'b0;
        end else if (state.io_cfg[`IO_POL_BIT]) begin
            next_state.io_trigger = !state.io_level && new_level;
        end else begin
            next_state.io_trigger = state.io_level && !new_level;
        end

        // Switching line output path
        next_state.vel_event = any_viol && state.io_cfg[`IO_VEL_MAP_BIT];
        next_state.io_oe_n = !state.io_cfg[`IO_DIR_BIT];
        if (!state.io_cfg[`IO_DIR_BIT]) begin
            next_state.io_out = 1'b0;
        end else if (state.io_cfg[`IO_POL_BIT]) begin
            next_state.io_out = next_state.vel_event;
        end else begin
            next_state.io_out = !next_state.vel_event;
        end

        // Object dictionary access
        next_state.od_ack   = access;
        next_state.od_err   = 1'b0;
        next_state.od_rdata = 32'h0000_0000;
        if (!access) begin
            next_state.od_ack = 1'b0;
        end else if (is_mon && od_wr) begin
            if (od_sub == `SUB_CFG) begin
                next_state.cfg[m] = vel_cfg_t'(od_wdata[2:0]);
                next_state.od_err = (od_wdata & ~{24'h00_0000, `CFG_MASK}) != 32'h0;
                if (next_state.od_err) begin
                    next_state.cfg[m] = state.cfg[m];
                end
            end else if (od_sub == `SUB_THR) begin
                if (bad_speed) begin
                    next_state.od_err = 1'b1;
                end else begin
                    next_state.thr[m] = od_wdata[15:0];
                end
            end else if (od_sub == `SUB_HYST) begin
                if (bad_speed) begin
                    next_state.od_err = 1'b1;
                end else begin
                    next_state.hyst[m] = od_wdata[15:0];
                end
            end else if (od_sub == `SUB_START) begin
                if (bad_pos) begin
                    next_state.od_err = 1'b1;
                end else begin
                    next_state.wstart[m] = od_wdata;
                end
            end else if (od_sub == `SUB_END) begin
                if (bad_pos) begin
                    next_state.od_err = 1'b1;
                end else begin
                    next_state.wend[m] = od_wdata;
                end
            end else begin
                next_state.od_err = 1'b1;
            end
        end else if (is_mon) begin
            if (od_sub == `SUB_COUNT) begin
                next_state.od_rdata = {24'h00_0000, `SUB_LAST};
            end else if (od_sub == `SUB_CFG) begin
                next_state.od_rdata = {29'h0000_0000, state.cfg[m]};
            end else if (od_sub == `SUB_THR) begin
                next_state.od_rdata = {16'h0000, state.thr[m]};
            end else if (od_sub == `SUB_HYST) begin
                next_state.od_rdata = {16'h0000, state.hyst[m]};
            end else if (od_sub == `SUB_START) begin
                next_state.od_rdata = state.wstart[m];
            end else if (od_sub == `SUB_END) begin
                next_state.od_rdata = state.wend[m];
            end else begin
                next_state.od_err = 1'b1;
            end
        end else if (od_index == `IDX_STATUS && od_sub == `SUB_COUNT) begin
            if (od_wr) begin
                next_state.od_err = 1'b1;
            end else begin
                next_state.od_rdata = {19'h0_0000, state.status};
            end
        end else if (od_index == `IDX_IO1 && od_sub == `SUB_COUNT) begin
            if (od_wr) begin
                next_state.io_cfg = od_wdata & `IO_CFG_MASK;
            end else begin
                next_state.od_rdata = state.io_cfg;
            end
        end else begin
            next_state.od_err = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state <= STATE_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign od_rdata       = state.od_rdata;
    assign od_ack         = state.od_ack;
    assign od_err         = state.od_err;
    assign io1_out        = state.io_out;
    assign io1_oe_n       = state.io_oe_n;
    assign io1_trigger    = state.io_trigger;
    assign speed_status   = state.status;
    assign velocity_event = state.vel_event;

    a_status_error: assert property (@(posedge mclk) disable iff (!reset_n)
        vel_error |=> speed_status[`ST_ERR_BIT])
        else $error("error bit not set");

    a_status_move: assert property (@(posedge mclk) disable iff (!reset_n)
        (velocity != 32'sh0000_0000) |=> speed_status[`ST_MOVE_BIT])
        else $error("movement bit not set");

    a_status_dir: assert property (@(posedge mclk) disable iff (!reset_n)
        ##1 speed_status[`ST_NEG_BIT] == $past(velocity[31]))
        else $error("direction bit wrong");

    a_status_viol: assert property (@(posedge mclk) disable iff (!reset_n)
        ##1 speed_status[7:3] == $past({mon_viol, monitor1_violation}))
        else $error("violation bits wrong");

    a_status_act: assert property (@(posedge mclk) disable iff (!reset_n)
        ##1 speed_status[12:8] == $past({mon_act, monitor1_active}))
        else $error("active bits wrong");

    a_line_dir: assert property (@(posedge mclk) disable iff (!reset_n)
        (od_wr && od_index == `IDX_IO1 && od_sub == `SUB_COUNT && od_wdata[0])
        |=> ##1 !io1_oe_n)
        else $error("line not driven as output");

    a_line_pol: assert property (@(posedge mclk) disable iff (!reset_n)
        (!io1_oe_n && velocity_event) |-> io1_out == $past(state.io_cfg[`IO_POL_BIT]))
        else $error("line level wrong for event");

    a_line_event: assert property (@(posedge mclk) disable iff (!reset_n)
        ((|mon_viol) && state.io_cfg[`IO_VEL_MAP_BIT]) |=> velocity_event)
        else $error("event missing for violation");

    a_speed_range: assert property (@(posedge mclk) disable iff (!reset_n)
        (od_wr && is_mon && od_sub == `SUB_THR && bad_speed) |=> od_err && $stable(state.thr))
        else $error("out of range threshold stored");

    a_reserved_zero: assert property (@(posedge mclk) disable iff (!reset_n)
        state.io_cfg[7:2] == 6'h00)
        else $error("reserved line bits set");

endmodule : velocity_limit_monitor

`default_nettype wire

// ---- od_master.sv ----
`timescale 1ns/1ps
`default_nettype none

module od_master (
    // Clock
    input  wire logic        mclk,
    // Access request
    output logic [15:0]      od_index,
    output logic [7:0]       od_sub,
    output logic             od_wr,
    output logic             od_rd,
    output logic [31:0]      od_wdata,
    // Answer
    input  wire logic [31:0] od_rdata,
    input  wire logic        od_ack,
    input  wire logic        od_err
);
    initial begin
        od_index = 16'h0000;
        od_sub   = 8'h00;
        od_wr    = 1'b0;
        od_rd    = 1'b0;
        od_wdata = 32'h0000_0000;
    end

    // One access: a single-cycle strobe, answer taken one cycle later
    task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                          input logic [31:0] wdata, output logic [31:0] rdata,
                          output logic err);
        int n;
        n = 0;
        @(negedge mclk);
        od_index = idx;
        od_sub   = sub;
        od_wdata = wdata;
        od_wr    = wr;
        od_rd    = !wr;
        @(negedge mclk);
        od_wr    = 1'b0;
        od_rd    = 1'b0;
        // Released lines show no stale value
        od_index = ~idx;
        od_sub   = ~sub;
        od_wdata = ~wdata;
        while (od_ack !== 1'b1 && n < 4) begin
            @(negedge mclk);
            n++;
        end
        rdata = (od_ack === 1'b1) ? od_rdata : 32'hxxxx_xxxx;
        err   = (od_ack === 1'b1) ? od_err : 1'bx;
    endtask : access
endmodule : od_master

`default_nettype wire

// ---- tb_velocity_limit_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_velocity_limit_monitor;
    logic               mclk               = 1'b0;
    logic               reset_n            = 1'b0;
    logic signed [31:0] position           = 32'sh0;
    logic signed [31:0] velocity           = 32'sh0;
    logic               vel_error          = 1'b0;
    logic               monitor1_violation = 1'b0;
    logic               monitor1_active    = 1'b0;
    logic               io1_in             = 1'b0;
    logic [15:0]        od_index;
    logic [7:0]         od_sub;
    logic               od_wr;
    logic               od_rd;
    logic [31:0]        od_wdata;
    logic [31:0]        od_rdata;
    logic               od_ack;
    logic               od_err;
    logic               io1_out;
    logic               io1_oe_n;
    logic               io1_trigger;
    logic [12:0]        speed_status;
    logic               velocity_event;
    int                 n_errors           = 0;
    int                 comparisons        = 0;

    always #25 mclk = ~mclk;

    velocity_limit_monitor u_velocity_limit_monitor (
        .mclk(mclk), .reset_n(reset_n), .position(position), .velocity(velocity),
        .vel_error(vel_error), .monitor1_violation(monitor1_violation),
        .monitor1_active(monitor1_active), .od_index(od_index), .od_sub(od_sub),
        .od_wr(od_wr), .od_rd(od_rd), .od_wdata(od_wdata), .od_rdata(od_rdata),
        .od_ack(od_ack), .od_err(od_err), .io1_in(io1_in), .io1_out(io1_out),
        .io1_oe_n(io1_oe_n), .io1_trigger(io1_trigger), .speed_status(speed_status),
        .velocity_event(velocity_event)
    );

    od_master u_od_master (
        .mclk(mclk), .od_index(od_index), .od_sub(od_sub), .od_wr(od_wr), .od_rd(od_rd),
        .od_wdata(od_wdata), .od_rdata(od_rdata), .od_ack(od_ack), .od_err(od_err)
    );

    task automatic end_sim;
        $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_sim

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check

    task automatic wr(input logic [15:0] i, input logic [7:0] s, input logic [31:0] d,
                      input logic e);
        logic [31:0] r;
        logic        er;
        u_od_master.access(1'b1, i, s, d, r, er);
        check("write refusal", {31'h0, e}, {31'h0, er});
    endtask : wr

    task automatic rd(input logic [15:0] i, input logic [7:0] s, input logic [31:0] e);
        logic [31:0] r;
        logic        er;
        u_od_master.access(1'b0, i, s, 32'h0000_0000, r, er);
        check("read refusal", 32'h0, {31'h0, er});
        check("read data", e, r);
    endtask : rd

    task automatic setup(input logic [15:0] i, input logic [31:0] t, s, e, c);
        wr(i, 8'h02, t, 1'b0);
        wr(i, 8'h04, s, 1'b0);
        wr(i, 8'h05, e, 1'b0);
        wr(i, 8'h01, c, 1'b0);
    endtask : setup

    task automatic drive(input int p, input int v);
        @(negedge mclk);
        position = p;
        velocity = v;
        repeat (4) @(negedge mclk);
    endtask : drive

    task automatic st(input logic [4:0] act, input logic [4:0] viol);
        check("speed_status", {19'h0, act, viol, velocity < 0, velocity != 0, vel_error},
              {19'h0, speed_status});
    endtask : st

    task automatic t_regs;
        for (int k = 0; k < 4; k++) begin
            rd(16'h2022 + 16'(k), 8'h00, 32'h0000_0005);
            rd(16'h2022 + 16'(k), 8'h01, 32'h0000_0000);
            rd(16'h2022 + 16'(k), 8'h02, 32'h0000_0000);
            rd(16'h2022 + 16'(k), 8'h03, 32'h0000_0064);
            rd(16'h2022 + 16'(k), 8'h04, 32'h0000_0000);
            rd(16'h2022 + 16'(k), 8'h05, 32'h0000_0000);
        end
        rd(16'h2050, 8'h00, 32'h0000_0000);
        $display("test register reset values done");
    endtask : t_regs

    task automatic t_refuse;
        wr(16'h2022, 8'h02, 32'h0000_4e21, 1'b1);
        rd(16'h2022, 8'h02, 32'h0000_0000);
        wr(16'h2022, 8'h02, 32'h0000_4e20, 1'b0);
        rd(16'h2022, 8'h02, 32'h0000_4e20);
        wr(16'h2023, 8'h03, 32'h0000_4e21, 1'b1);
        wr(16'h2025, 8'h01, 32'h0000_0008, 1'b1);
        wr(16'h2022, 8'h04, 32'h000f_4240, 1'b1);
        wr(16'h2026, 8'h00, 32'h0000_0000, 1'b1);
        wr(16'h2027, 8'h01, 32'h0000_0000, 1'b1);
        wr(16'h2022, 8'h06, 32'h0000_0000, 1'b1);
        wr(16'h2022, 8'h02, 32'h0000_0000, 1'b0);
        $display("test refused accesses done");
    endtask : t_refuse

    task automatic t_status;
        @(negedge mclk);
        vel_error          = 1'b1;
        monitor1_violation = 1'b1;
        monitor1_active    = 1'b1;
        drive(0, -5);
        st(5'h01, 5'h01);
        rd(16'h2026, 8'h00, 32'h0000_010f);
        vel_error          = 1'b0;
        monitor1_violation = 1'b0;
        monitor1_active    = 1'b0;
        drive(0, 7);
        st(5'h00, 5'h00);
        drive(0, 0);
        st(5'h00, 5'h00);
        $display("test status flags done");
    endtask : t_status

    task automatic t_exceed;
        setup(16'h2022, 32'h0000_03e8, 32'hffff_fc18, 32'h0000_03e8, 32'h0000_0004);
        drive(0, 1001);
        st(5'h02, 5'h02);
        drive(0, 950);
        st(5'h02, 5'h02);
        drive(0, 900);
        st(5'h02, 5'h00);
        drive(0, -1001);
        st(5'h02, 5'h02);
        drive(2000, 1001);
        st(5'h00, 5'h00);
        drive(0, 1001);
        wr(16'h2022, 8'h01, 32'h0000_0000, 1'b0);
        drive(0, 1001);
        st(5'h00, 5'h00);
        $display("test exceed mode done");
    endtask : t_exceed

    task automatic t_below;
        setup(16'h2023, 32'h0000_01f4, 32'hffff_fc18, 32'h0000_03e8, 32'h0000_0005);
        drive(0, 600);
        st(5'h04, 5'h00);
        drive(0, 499);
        st(5'h04, 5'h04);
        drive(0, 599);
        st(5'h04, 5'h04);
        drive(0, 600);
        st(5'h04, 5'h00);
        wr(16'h2023, 8'h01, 32'h0000_0000, 1'b0);
        $display("test below mode done");
    endtask : t_below

    task automatic t_dir;
        setup(16'h2024, 32'h0000_0064, 32'h0000_03e8, 32'hffff_fc18, 32'h0000_0006);
        drive(0, 200);
        st(5'h00, 5'h00);
        drive(0, -200);
        st(5'h08, 5'h08);
        wr(16'h2024, 8'h01, 32'h0000_0000, 1'b0);
        $display("test direction done");
    endtask : t_dir

    task automatic t_window_io;
        wr(16'h2025, 8'h01, 32'h0000_0004, 1'b0);
        drive(0, 500);
        st(5'h00, 5'h00);
        wr(16'h2025, 8'h05, 32'h0000_0064, 1'b0);
        drive(0, 500);
        st(5'h10, 5'h10);
        wr(16'h2050, 8'h00, 32'h0000_04ff, 1'b0);
        rd(16'h2050, 8'h00, 32'h0000_0403);
        drive(0, 500);
        check("io1_oe_n", 32'h0, {31'h0, io1_oe_n});
        check("io1_out", 32'h1, {31'h0, io1_out});
        check("velocity_event", 32'h1, {31'h0, velocity_event});
        wr(16'h2050, 8'h00, 32'h0000_0401, 1'b0);
        drive(0, 500);
        check("io1_out", 32'h0, {31'h0, io1_out});
        drive(200, 0);
        check("io1_out", 32'h1, {31'h0, io1_out});
        check("velocity_event", 32'h0, {31'h0, velocity_event});
        monitor1_violation = 1'b1;
        drive(0, 0);
        check("velocity_event", 32'h1, {31'h0, velocity_event});
        monitor1_violation = 1'b0;
        wr(16'h2025, 8'h01, 32'h0000_0000, 1'b0);
        $display("test window and output line done");
    endtask : t_window_io

    task automatic pulses(input logic lvl, input int exp);
        int n;
        n = 0;
        @(negedge mclk);
        io1_in = lvl;
        repeat (10) @(negedge mclk) if (io1_trigger === 1'b1) n++;
        check("io1_trigger count", exp, n);
    endtask : pulses

    task automatic t_io_in;
        wr(16'h2050, 8'h00, 32'h0000_0000, 1'b0);
        drive(0, 0);
        check("io1_oe_n", 32'h1, {31'h0, io1_oe_n});
        pulses(1'b1, 0);
        pulses(1'b0, 1);
        wr(16'h2050, 8'h00, 32'h0000_0002, 1'b0);
        pulses(1'b1, 1);
        pulses(1'b0, 0);
        $display("test input line done");
    endtask : t_io_in

    initial begin
        repeat (16) @(negedge mclk);
        reset_n = 1'b1;
        t_regs();
        t_refuse();
        t_status();
        t_exceed();
        t_below();
        t_dir();
        t_window_io();
        t_io_in();
        end_sim();
    end

    initial begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        end_sim();
    end
endmodule : tb_velocity_limit_monitor

`default_nettype wire
